// ---- asp_device.sv ----
// Purpose: 8/9-bit asynchronous serial port with control and data registers.
// Assumes: t1_tick is the timer clock enable from the same clock domain.
// Notes:   Register reads return one cycle after the address is presented.
//
// The implementer's own choice: the sfr_addr/sfr_wr byte port to the registers.
`timescale 1ns/1ps
module asp_device (
  // Clock, reset and freeze
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  // Bit rate source
  input  wire logic       t1_tick,
  input  wire logic [7:0] baud_reload_value,
  // Register port
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  output logic      [7:0] sfr_rdata,
  // Interrupt
  input  wire logic       int_enable,
  output logic            uart_irq,
  // Serial lines
  asp_link_if.device      link
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic                   frame_length_select;
  logic                   address_filter_enable;
  logic                   receive_enable_field;
  logic                   tx_ninth_bit;
  logic                   rx_ninth_bit;
  logic                   tx_done_flag;
  logic                   rx_done_flag;
  logic [7:0]             rx_latch;
  logic [7:0]             tx_hold;
  logic                   tx_pend;
  logic [9:0]             tx_shift;
  logic [10:0]            tx_image;
  logic [3:0]             tx_left;
  logic                   tx_line;
  logic [7:0]             tx_tl;
  logic [7:0]             rx_tl;
  logic                   tx_half;
  logic                   rx_half;
  logic [1:0]             rx_sync;
  logic                   rx_prev;
  asp_pkg::asp_rx_state_e rx_state;
  logic [3:0]             rx_cnt;
  logic [8:0]             rx_bits;
  logic                   ctrl_wr;
  logic                   data_wr;
  logic                   tx_ovf;
  logic                   tx_bit;
  logic                   rx_ovf;
  logic                   rx_sample;
  logic                   rx_line;
  logic                   stop_seen;
  logic                   filter_bit;
  logic                   accept;
  logic                   set_ti;
  logic                   set_ri;
  logic [7:0]             ctrl_image;

  assign ctrl_wr = ce && sfr_wr && (sfr_addr == asp_pkg::ASP_CTRL_ADDR);
  assign data_wr = ce && sfr_wr && (sfr_addr == asp_pkg::ASP_DATA_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // Transmit and receive timers, each a reloading copy of the timer low byte
  assign tx_ovf    = t1_tick && (tx_tl == asp_pkg::ASP_TL_WRAP);
  assign tx_bit    = tx_ovf && tx_half;
  assign rx_ovf    = t1_tick && (rx_tl == asp_pkg::ASP_TL_WRAP);
  // First overflow after a forced reload lands half a bit in: bit centre
  assign rx_sample = rx_ovf && !rx_half;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_tl   <= 8'h00;
      tx_half <= 1'b0;
    end else if (ce && t1_tick) begin
      tx_tl   <= tx_ovf ? baud_reload_value : tx_tl + 8'h01;
      tx_half <= tx_half ^ tx_ovf;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_tl   <= 8'h00;
      rx_half <= 1'b0;
    end else if (ce) begin
      if (stop_seen) begin
        rx_tl   <= baud_reload_value;
        rx_half <= 1'b0;
      end else if (t1_tick) begin
        rx_tl   <= rx_ovf ? baud_reload_value : rx_tl + 8'h01;
        rx_half <= rx_half ^ rx_ovf;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_hold <= 8'h00;
      tx_pend <= 1'b0;
    end else if (ce) begin
      if (data_wr) begin
        tx_hold <= sfr_wdata;
        tx_pend <= 1'b1;
      end else if (tx_bit && tx_left == 4'h0) begin
        tx_pend <= 1'b0;
      end
    end
  end

  // A write during a frame is held and sent right after the current stop bit
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_shift <= 10'h3ff;
      tx_left  <= 4'h0;
      tx_line  <= 1'b1;
    end else if (ce && tx_bit) begin
      if (tx_left != 4'h0) begin
        tx_line  <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_left  <= tx_left - 4'h1;
      end else if (tx_pend) begin
        tx_line  <= 1'b0;
        tx_shift <= tx_image[10:1];
        tx_left  <= asp_pkg::asp_data_bits(frame_length_select) + 4'h1;
      end else begin
        tx_line  <= 1'b1;
      end
    end
  end

  assign set_ti = ce && tx_bit && (tx_left == 4'h1);
  assign tx_image = asp_pkg::asp_frame(frame_length_select, tx_ninth_bit, tx_hold);
  ////////////////////////////////////////////////////////////////////////////
  // Receiver
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sync <= 2'b11;
      rx_prev <= 1'b1;
    end else if (ce) begin
      rx_sync <= {rx_sync[0], link.serial_in_line};
      rx_prev <= rx_sync[1];
    end
  end

  assign rx_line   = rx_sync[1];
  assign stop_seen = receive_enable_field && (rx_state == asp_pkg::asp_rx_idle) &&
                     rx_prev && !rx_line;
  assign filter_bit = frame_length_select ? rx_bits[8] : rx_line;
  assign accept     = !rx_done_flag && (!address_filter_enable || filter_bit);
  assign set_ri     = ce && rx_sample && (rx_state == asp_pkg::asp_rx_stop) &&
                      accept;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= asp_pkg::asp_rx_idle;
      rx_cnt   <= 4'h0;
      rx_bits  <= 9'h000;
    end else if (ce) begin
      case (rx_state)
        asp_pkg::asp_rx_idle: begin
          rx_cnt <= 4'h0;
          if (stop_seen) begin
            rx_state <= asp_pkg::asp_rx_start;
          end
        end
        asp_pkg::asp_rx_start: begin
          if (rx_sample) begin
            // A high centre means a glitch, not a start bit
            rx_state <= rx_line ? asp_pkg::asp_rx_idle : asp_pkg::asp_rx_data;
          end
        end
        asp_pkg::asp_rx_data: begin
          if (rx_sample) begin
            rx_bits[rx_cnt] <= rx_line;
            rx_cnt          <= rx_cnt + 4'h1;
            if (rx_cnt == asp_pkg::asp_data_bits(frame_length_select) - 4'h1) begin
              rx_state <= asp_pkg::asp_rx_stop;
            end
          end
        end
        asp_pkg::asp_rx_stop: begin
          if (rx_sample) begin
            rx_state <= asp_pkg::asp_rx_idle;
          end
        end
        default: rx_state <= asp_pkg::asp_rx_idle;
      endcase
    end
  end

  // Rejected frames leave buffer and ninth bit untouched
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_latch     <= 8'h00;
      rx_ninth_bit <= 1'b0;
    end else if (set_ri) begin
      rx_latch     <= rx_bits[7:0];
      rx_ninth_bit <= filter_bit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Control register; a hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_length_select   <= asp_pkg::ASP_CTRL_RESET[asp_pkg::ASP_MODE_BIT];
      address_filter_enable <= asp_pkg::ASP_CTRL_RESET[asp_pkg::ASP_MCE_BIT];
      receive_enable_field  <= asp_pkg::ASP_CTRL_RESET[asp_pkg::ASP_REN_BIT];
      tx_ninth_bit          <= asp_pkg::ASP_CTRL_RESET[asp_pkg::ASP_TB8_BIT];
    end else if (ctrl_wr) begin
      frame_length_select   <= sfr_wdata[asp_pkg::ASP_MODE_BIT];
      address_filter_enable <= sfr_wdata[asp_pkg::ASP_MCE_BIT];
      receive_enable_field  <= sfr_wdata[asp_pkg::ASP_REN_BIT];
      tx_ninth_bit          <= sfr_wdata[asp_pkg::ASP_TB8_BIT];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_done_flag <= asp_pkg::ASP_CTRL_RESET[asp_pkg::ASP_TI_BIT];
      rx_done_flag <= asp_pkg::ASP_CTRL_RESET[asp_pkg::ASP_RI_BIT];
    end else if (ce) begin
      // Software may write either flag; hardware never clears them
      tx_done_flag <= set_ti || (ctrl_wr ? sfr_wdata[asp_pkg::ASP_TI_BIT]
                                         : tx_done_flag);
      rx_done_flag <= set_ri || (ctrl_wr ? sfr_wdata[asp_pkg::ASP_RI_BIT]
                                         : rx_done_flag);
    end
  end

  always_comb begin
    ctrl_image                         = 8'h00;
    ctrl_image[asp_pkg::ASP_MODE_BIT]  = frame_length_select;
    ctrl_image[asp_pkg::ASP_ONE_BIT]   = 1'b1;
    ctrl_image[asp_pkg::ASP_MCE_BIT]   = address_filter_enable;
    ctrl_image[asp_pkg::ASP_REN_BIT]   = receive_enable_field;
    ctrl_image[asp_pkg::ASP_TB8_BIT]   = tx_ninth_bit;
    ctrl_image[asp_pkg::ASP_RB8_BIT]   = rx_ninth_bit;
    ctrl_image[asp_pkg::ASP_TI_BIT]    = tx_done_flag;
    ctrl_image[asp_pkg::ASP_RI_BIT]    = rx_done_flag;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sfr_rdata <= 8'h00;
    end else if (ce) begin
      if (sfr_addr == asp_pkg::ASP_CTRL_ADDR) begin
        sfr_rdata <= ctrl_image;
      end else if (sfr_addr == asp_pkg::ASP_DATA_ADDR) begin
        sfr_rdata <= rx_latch;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      uart_irq <= 1'b0;
    end else if (ce) begin
      uart_irq <= int_enable && (tx_done_flag || rx_done_flag);
    end
  end

  assign link.serial_out_line = tx_line;

endmodule : asp_device

// ---- asp_pkg.sv ----
// Purpose: Shared constants, types and helpers for the serial port pair.
// Assumes: Both ends run on aclk; bit timing comes from each end's own divider.
// Notes:   Frame shape and receive states are shared by both ends; each register map serves one end.
package asp_pkg;

  // Register addresses and reset value of the device port
  localparam logic [7:0] ASP_CTRL_ADDR  = 8'h98;
  localparam logic [7:0] ASP_DATA_ADDR  = 8'h99;
  localparam logic [7:0] ASP_CTRL_RESET = 8'h40;

  // Control field positions
  localparam int ASP_MODE_BIT = 7;
  localparam int ASP_ONE_BIT  = 6;
  localparam int ASP_MCE_BIT  = 5;
  localparam int ASP_REN_BIT  = 4;
  localparam int ASP_TB8_BIT  = 3;
  localparam int ASP_RB8_BIT  = 2;
  localparam int ASP_TI_BIT   = 1;
  localparam int ASP_RI_BIT   = 0;

  // Frame shape
  localparam logic [3:0] ASP_BITS_8   = 4'h8;
  localparam logic [3:0] ASP_BITS_9   = 4'h9;
  localparam logic [7:0] ASP_TL_WRAP  = 8'hff;

  // Far end register map (AXI4-Lite byte addresses)
  localparam logic [7:0] ASP_FE_CTRL   = 8'h00;
  localparam logic [7:0] ASP_FE_STATUS = 8'h04;
  localparam logic [7:0] ASP_FE_TXDATA = 8'h08;
  localparam logic [7:0] ASP_FE_RXDATA = 8'h0c;
  localparam int ASP_FE_MODE_BIT  = 0;
  localparam int ASP_FE_TB8_BIT   = 1;
  localparam int ASP_FE_HALF_LSB  = 16;
  localparam logic [15:0] ASP_FE_HALF_RESET = 16'h0080;
  localparam logic [1:0] ASP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ASP_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    asp_rx_idle  = 2'b00,
    asp_rx_start = 2'b01,
    asp_rx_data  = 2'b10,
    asp_rx_stop  = 2'b11
  } asp_rx_state_e;

  // Data bits per frame, ninth bit included in 9-bit mode
  function automatic logic [3:0] asp_data_bits(input logic nine);
    return nine ? ASP_BITS_9 : ASP_BITS_8;
  endfunction : asp_data_bits

  // Transmit frame image, LSB leaves first: start, data, ninth or stop, stop
  function automatic logic [10:0] asp_frame(input logic nine, input logic tb8,
                                            input logic [7:0] data);
    return {1'b1, nine ? tb8 : 1'b1, data, 1'b0};
  endfunction : asp_frame

endpackage : asp_pkg

// ---- asp_link_if.sv ----
// Purpose: Serial line pair between the port and its remote partner.
// Assumes: Both lines are driven push-pull and idle high.
// Notes:   No clocking; each end synchronises what it receives.
`timescale 1ns/1ps
interface asp_link_if;
  logic serial_out_line;
  logic serial_in_line;

  modport device (output serial_out_line, input serial_in_line);
  modport far    (output serial_in_line, input serial_out_line);
endinterface : asp_link_if

// ---- asp_far_end.sv ----
// Purpose: Remote serial partner, commanded over AXI4-Lite.
// Assumes: Half-bit time in aclk cycles is set in the control register.
// Notes:   Receive always captures; status shows the last frame.
`timescale 1ns/1ps
module asp_far_end (
  // Clock, reset and freeze
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  // AXI4-Lite write
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic      [1:0]  s_axi_bresp,
  // AXI4-Lite read
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  // Serial lines
  asp_link_if.far          link
);

  logic                   nine;
  logic                   tb8;
  logic [15:0]            half;
  logic [7:0]             aw_addr;
  logic                   aw_full;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   w_full;
  logic                   do_wr;
  logic                   tx_go;
  logic [9:0]             tx_shift;
  logic [10:0]            tx_image;
  logic [3:0]             tx_left;
  logic [16:0]            tx_cnt;
  logic                   tx_line;
  logic                   tx_busy;
  logic [1:0]             rx_sync;
  logic                   rx_prev;
  asp_pkg::asp_rx_state_e rx_state;
  logic [3:0]             rx_cnt;
  logic [16:0]            rx_tmr;
  logic [8:0]             rx_bits;
  logic [8:0]             rx_word;
  logic                   rx_stop;
  logic                   rx_full;
  logic                   rx_tick;
  logic                   rd_rx;

  assign do_wr   = ce && aw_full && w_full && !s_axi_bvalid;
  assign tx_go   = do_wr && aw_addr == asp_pkg::ASP_FE_TXDATA && w_strb[0] && !tx_busy;
  assign tx_busy = (tx_left != 4'h0) || (tx_cnt != 17'h0);
  assign tx_image = asp_pkg::asp_frame(nine, tb8, w_data[7:0]);
  assign rx_tick = (rx_state != asp_pkg::asp_rx_idle) && (rx_tmr == 17'h0);
  assign rd_rx   = ce && s_axi_arvalid && s_axi_arready &&
                   s_axi_araddr == asp_pkg::ASP_FE_RXDATA;

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite slave; address and data captured in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 8'h00;
      w_data  <= 32'h0;
      w_strb  <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= asp_pkg::ASP_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_wr) begin
        aw_full      <= 1'b0;
        w_full       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr == asp_pkg::ASP_FE_CTRL ||
                         aw_addr == asp_pkg::ASP_FE_TXDATA) ?
                        asp_pkg::ASP_RESP_OKAY : asp_pkg::ASP_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      nine <= 1'b0;
      tb8  <= 1'b0;
      half <= asp_pkg::ASP_FE_HALF_RESET;
    end else if (do_wr && aw_addr == asp_pkg::ASP_FE_CTRL) begin
      if (w_strb[0]) begin
        nine <= w_data[asp_pkg::ASP_FE_MODE_BIT];
        tb8  <= w_data[asp_pkg::ASP_FE_TB8_BIT];
      end
      if (w_strb[2] && w_strb[3]) begin
        half <= w_data[asp_pkg::ASP_FE_HALF_LSB +: 16];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= asp_pkg::ASP_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= asp_pkg::ASP_RESP_OKAY;
        case (s_axi_araddr)
          asp_pkg::ASP_FE_CTRL:   s_axi_rdata <= {half, 14'h0, tb8, nine};
          asp_pkg::ASP_FE_STATUS: s_axi_rdata <= {28'h0, rx_stop, rx_word[8],
                                                  rx_full, tx_busy};
          asp_pkg::ASP_FE_RXDATA: s_axi_rdata <= {23'h0, rx_word};
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= asp_pkg::ASP_RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transmitter: each bit lasts two half-bit times
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_shift <= 10'h3ff;
      tx_left  <= 4'h0;
      tx_cnt   <= 17'h0;
      tx_line  <= 1'b1;
    end else if (ce) begin
      if (tx_go) begin
        tx_line  <= 1'b0;
        tx_shift <= tx_image[10:1];
        tx_left  <= asp_pkg::asp_data_bits(nine) + 4'h1;
        tx_cnt   <= {half, 1'b0} - 17'h1;
      end else if (tx_cnt != 17'h0) begin
        tx_cnt <= tx_cnt - 17'h1;
      end else if (tx_left != 4'h0) begin
        tx_line  <= tx_shift[0];
        tx_shift <= {1'b1, tx_shift[9:1]};
        tx_left  <= tx_left - 4'h1;
        tx_cnt   <= {half, 1'b0} - 17'h1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Receiver: start on falling edge, sample at each bit centre
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_sync <= 2'b11;
      rx_prev <= 1'b1;
    end else if (ce) begin
      rx_sync <= {rx_sync[0], link.serial_out_line};
      rx_prev <= rx_sync[1];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_state <= asp_pkg::asp_rx_idle;
      rx_cnt   <= 4'h0;
      rx_tmr   <= 17'h0;
      rx_bits  <= 9'h000;
    end else if (ce) begin
      rx_tmr <= rx_tick ? {half, 1'b0} - 17'h1 : rx_tmr - 17'h1;
      case (rx_state)
        asp_pkg::asp_rx_idle: begin
          rx_cnt <= 4'h0;
          if (rx_prev && !rx_sync[1]) begin
            rx_state <= asp_pkg::asp_rx_start;
            rx_tmr   <= {1'b0, half} - 17'h1;
          end
        end
        asp_pkg::asp_rx_start: begin
          if (rx_tick) begin
            rx_state <= rx_sync[1] ? asp_pkg::asp_rx_idle : asp_pkg::asp_rx_data;
          end
        end
        asp_pkg::asp_rx_data: begin
          if (rx_tick) begin
            rx_bits[rx_cnt] <= rx_sync[1];
            rx_cnt          <= rx_cnt + 4'h1;
            if (rx_cnt == asp_pkg::asp_data_bits(nine) - 4'h1) begin
              rx_state <= asp_pkg::asp_rx_stop;
            end
          end
        end
        asp_pkg::asp_rx_stop: begin
          if (rx_tick) begin
            rx_state <= asp_pkg::asp_rx_idle;
          end
        end
        default: rx_state <= asp_pkg::asp_rx_idle;
      endcase
    end
  end

  // A frame ending in the same cycle as the data read keeps full set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_word <= 9'h000;
      rx_stop <= 1'b0;
      rx_full <= 1'b0;
    end else if (ce) begin
      if (rx_tick && rx_state == asp_pkg::asp_rx_stop) begin
        rx_word <= nine ? rx_bits : {1'b0, rx_bits[7:0]};
        rx_stop <= rx_sync[1];
        rx_full <= 1'b1;
      end else if (rd_rx) begin
        rx_full <= 1'b0;
      end
    end
  end

  assign link.serial_in_line = tx_line;

endmodule : asp_far_end

// ---- asp_checker.sv ----
// Purpose: Line-level checks on the serial pair between device and far end.
// Assumes: Both ends run eight-cycle bits (reload 0xfc, far half-bit 4).
// Notes:   Frame starts are tracked by an 80-cycle window after each start.
`timescale 1ns/1ps
module asp_checker (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Serial lines
  input wire logic serial_out_line,
  input wire logic serial_in_line
);
  wire       tx_l = serial_out_line;
  wire       rx_l = serial_in_line;
  logic [6:0] tx_cnt;
  logic [6:0] rx_cnt;
  // A low level seen outside a frame window is a start bit
  wire       tx_fs = (tx_cnt == 7'h00) && !tx_l;
  wire       rx_fs = (rx_cnt == 7'h00) && !rx_l;
  always_ff @(posedge aclk) begin
    if (!aresetn || tx_cnt == 7'h4f)
      tx_cnt <= 7'h00;
    else if (tx_cnt != 7'h00 || tx_fs)
      tx_cnt <= tx_cnt + 7'h01;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || rx_cnt == 7'h4f)
      rx_cnt <= 7'h00;
    else if (rx_cnt != 7'h00 || rx_fs)
      rx_cnt <= rx_cnt + 7'h01;
  end
  //////////////////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tx_bit_hold: assert property ($changed(tx_l) |=> $stable(tx_l)[*7])
    else $error("tx bit shorter than eight cycles");
  a_rx_bit_hold: assert property ($changed(rx_l) |=> $stable(rx_l)[*7])
    else $error("rx bit shorter than eight cycles");
  a_tx_start_low: assert property (tx_fs |-> (!tx_l)[*8])
    else $error("tx start bit not eight cycles low");
  a_rx_start_low: assert property (rx_fs |-> (!rx_l)[*8])
    else $error("rx start bit not eight cycles low");
  a_tx_idle_high: assert property (tx_fs |-> $past(tx_l))
    else $error("tx frame not preceded by high line");
  a_rx_idle_high: assert property (rx_fs |-> $past(rx_l))
    else $error("rx frame not preceded by high line");
  a_tx_stop_high: assert property (tx_fs |-> (##72 tx_l) or (##80 tx_l))
    else $error("tx stop bit missing");
  a_rx_stop_high: assert property (rx_fs |-> (##72 rx_l) or (##80 rx_l))
    else $error("rx stop bit missing");
endmodule : asp_checker

// ---- tb_async_serial_port_8_9_bit.sv ----
// Purpose: Random 8/9-bit frames both ways between device and far end.
// Assumes: Eight-cycle bits on both ends.
// Notes:   The device receive flag is left set at random to provoke overrun.
`timescale 1ns/1ps
module tb_async_serial_port_8_9_bit;
  localparam logic [7:0] CA = asp_pkg::ASP_CTRL_ADDR;
  localparam logic [7:0] DA = asp_pkg::ASP_DATA_ADDR;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        int_enable = 1'b0;
  logic        sfr_wr = 1'b0;
  logic [7:0]  sfr_addr = 8'h00, sfr_wdata = 8'h00, ax = 8'h00, sfr_rdata;
  logic [4:0]  vld = 5'h00;
  logic [31:0] wd = 32'h0, rd;
  logic        uart_irq, awr, wr, bv, arr, rv;
  logic [1:0]  br, rr;
  int          n_errors = 0, compares = 0;
  asp_link_if link ();
  always #2.5 aclk = ~aclk;
  // Reload 0xfc: four ticks per overflow, eight-cycle bits
  asp_device u_asp_device (.aclk, .aresetn, .ce(1'b1), .t1_tick(1'b1), .baud_reload_value(8'hfc),
    .sfr_addr, .sfr_wr, .sfr_wdata, .sfr_rdata, .int_enable, .uart_irq, .link);
  asp_far_end u_asp_far_end (.aclk, .aresetn, .ce(1'b1), .s_axi_awvalid(vld[4]),
    .s_axi_awready(awr), .s_axi_awaddr(ax), .s_axi_wvalid(vld[3]), .s_axi_wready(wr),
    .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_bvalid(bv), .s_axi_bready(vld[2]),
    .s_axi_bresp(br), .s_axi_arvalid(vld[1]), .s_axi_arready(arr), .s_axi_araddr(ax),
    .s_axi_rvalid(rv), .s_axi_rready(vld[0]), .s_axi_rdata(rd), .s_axi_rresp(rr), .link);
  asp_checker u_asp_checker (.aclk, .aresetn, .serial_out_line(link.serial_out_line),
    .serial_in_line(link.serial_in_line));
  //////////////////////////////////////////////////////////////////////////////////////////
  task automatic end_sim();
    if (n_errors == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic to(inout int i);
    i++;
    if (i > 200) begin
      n_errors++;
      end_sim();
    end
  endtask : to
  // One write or one read; each valid drops right after the edge that takes it
  task automatic axi(input bit w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    logic [4:0] p;
    int         i;
    p = w ? 5'h1c : 5'h03;
    i = 0;
    ax <= a;
    wd <= d;
    while (p != 5'h00) begin
      vld <= p;
      @(posedge aclk);
      if (p[0] && rv) begin
        q = rd;
        chk("rresp", asp_pkg::ASP_RESP_OKAY, rr);
      end
      if (p[2] && bv)
        chk("bresp", asp_pkg::ASP_RESP_OKAY, br);
      p = p & ~{awr, wr, bv, arr, rv};
      to(i);
    end
    vld <= 5'h00;
    @(posedge aclk);
  endtask : axi
  task automatic fwait(input int b, input logic lvl, output logic [31:0] s);
    int i;
    i = 0;
    do begin
      axi(1'b0, asp_pkg::ASP_FE_STATUS, 32'h0, s);
      to(i);
    end while (s[b] !== lvl);
  endtask : fwait
  task automatic sfw(input logic [7:0] a, input logic [7:0] d);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge aclk);
    sfr_wr <= 1'b0;
    @(posedge aclk);
  endtask : sfw
  task automatic sfrd(input logic [7:0] a, output logic [7:0] q);
    sfr_addr <= a;
    repeat (2) @(posedge aclk);
    q = sfr_rdata;
  endtask : sfrd
  //////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q, r;
    logic [7:0]  c;
    bit          nine, tb8, mce, ren, b;
    int          ri, rb8, buf_q;
    ri = 0;
    rb8 = 0;
    buf_q = 0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    r = $urandom(36443);
    sfrd(CA, c);
    chk("ctrl reset", 8'h40, c);
    sfw(CA, 8'h00);
    sfrd(CA, c);
    chk("ctrl spare bit", 8'h40, c);
    for (int k = 0; k < 8; k++) begin
      r = $urandom;
      nine = k[0];
      tb8 = r[16];
      mce = r[17];
      ren = r[18];
      b = r[21];
      int_enable <= r[20];
      axi(1'b1, asp_pkg::ASP_FE_CTRL, {16'h0004, 14'h0, b, nine}, q);
      sfw(CA, {nine, 3'b100, tb8, 2'b00, ri[0]});
      sfw(DA, r[7:0]);
      fwait(1, 1'b1, q);
      chk("far stop", 32'h8, q & 32'h8);
      axi(1'b0, asp_pkg::ASP_FE_RXDATA, 32'h0, q);
      chk("far rx", {nine & tb8, r[7:0]}, {nine & q[8], q[7:0]});
      sfrd(CA, c);
      chk("ctrl tx", {nine, 3'b100, tb8, rb8[0], 1'b1, ri[0]}, c);
      chk("irq", int_enable, uart_irq);
      ri = ri & r[19];
      sfw(CA, {nine, 1'b1, mce, ren, tb8, 2'b00, ri[0]});
      axi(1'b1, asp_pkg::ASP_FE_TXDATA, {24'h0, r[15:8]}, q);
      fwait(0, 1'b0, q);
      repeat (8) @(posedge aclk);
      if (ren && ri == 0 && (!mce || !nine || b)) begin
        buf_q = r[15:8];
        rb8 = nine ? b : 1;
        ri = 1;
      end
      sfrd(DA, c);
      chk("rx data", buf_q[7:0], c);
      sfrd(CA, c);
      chk("ctrl rx", {nine, 1'b1, mce, ren, tb8, rb8[0], 1'b0, ri[0]}, c);
      chk("irq rx", int_enable & ri[0], uart_irq);
    end
    end_sim();
  end
endmodule : tb_async_serial_port_8_9_bit
